/* inc/intc_pkg.sv */
`default_nettype none
package intc_pkg;
  localparam int unsigned NUM_SRC     = 12;
  localparam int unsigned MC_CLOCKS   = 6;
  localparam int unsigned MC_CNT_W    = 3;
  localparam int unsigned MIN_HOLD_CLK = 6;
  // source indices, in table order
  localparam int unsigned SRC_EXT0  = 0;
  localparam int unsigned SRC_TMR0  = 1;
  localparam int unsigned SRC_EXT1  = 2;
  localparam int unsigned SRC_TMR1  = 3;
  localparam int unsigned SRC_SER   = 4;
  localparam int unsigned SRC_BROWN = 5;
  localparam int unsigned SRC_I2C   = 6;
  localparam int unsigned SRC_KEY   = 7;
  localparam int unsigned SRC_CMP2  = 8;
  localparam int unsigned SRC_WDOG  = 9;
  localparam int unsigned SRC_CMP1  = 10;
  localparam int unsigned SRC_TMRI  = 11;
  // enable register bit positions
  localparam int unsigned EN_A_GATE_BIT = 7;
  localparam logic [NUM_SRC-1:0][3:0] EN_BIT_POS = {
    4'h7, 4'h5, 4'h6, 4'h2, 4'h1, 4'h0, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam logic [NUM_SRC-1:0] EN_IN_REG_B = 12'hDC0;
  localparam logic [NUM_SRC-1:0][15:0] VECTORS = {
    16'h0073, 16'h0063, 16'h0053, 16'h0043, 16'h003B, 16'h0033,
    16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};
  // rank 1 = highest
  localparam logic [NUM_SRC-1:0][3:0] RANK = {
    4'hC, 4'h8, 4'h3, 4'hA, 4'h7, 4'h5, 4'h2, 4'hB, 4'h9, 4'h6, 4'h4, 4'h1};
  localparam logic [NUM_SRC-1:0] WAKE_CAPABLE = 12'h7A5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] VECTOR_RESET = 16'h0000;
endpackage
`default_nettype wire

/* inc/arb_if.sv */
`default_nettype none
interface arb_if;
  logic [11:0] req;
  logic [11:0][1:0] prio;
  logic        any;
  logic [3:0]  idx;
  logic [1:0]  level;
  modport ctl (output req, output prio, input any, input idx, input level);
  modport arb (input req, input prio, output any, output idx, output level);
endinterface
`default_nettype wire

/* logic/prio_arbiter.sv */
`default_nettype none
module prio_arbiter (
  arb_if.arb a
);
  always_comb begin
    logic [4:0] best;
    best    = 5'h1F;
    a.any   = 1'b0;
    a.idx   = 4'h0;
    a.level = 2'h0;
    for (int i = 0; i < intc_pkg::NUM_SRC; i++) begin
      // higher level first, rank only on ties
      if (a.req[i] && (!a.any || a.prio[i] > a.level || (a.prio[i] == a.level &&
          {1'b0, intc_pkg::RANK[i]} < best))) begin
        a.any   = 1'b1;
        a.idx   = 4'(i);
        a.level = a.prio[i];
        best    = {1'b0, intc_pkg::RANK[i]};
      end
    end
  end
endmodule
`default_nettype wire

/* logic/priority_interrupt_controller.sv */
`default_nettype none
module priority_interrupt_controller (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  irq_enable_reg_a,
  input  wire logic [7:0]  irq_enable_reg_b,
  input  wire logic [7:0]  prio_low_reg_a,
  input  wire logic [7:0]  prio_high_reg_a,
  input  wire logic [7:0]  prio_low_reg_b,
  input  wire logic [7:0]  prio_high_reg_b,
  input  wire logic [1:0]  trigger_type_select,
  input  wire logic [1:0]  ext_irq_pin_n,
  input  wire logic        timer_zero_overflow,
  input  wire logic        timer_one_overflow,
  input  wire logic        serial_flag,
  input  wire logic        brownout_flag,
  input  wire logic        i2c_attention_flag,
  input  wire logic        keypad_flag,
  input  wire logic        comparator_two_flag,
  input  wire logic        watchdog_overflow_flag,
  input  wire logic        comparator_one_flag,
  input  wire logic        timer_i_flag,
  input  wire logic        irq_ack,
  input  wire logic        irq_return,
  input  wire logic        power_down,
  output logic             irq_req,
  output logic [15:0]      irq_vector,
  output logic [3:0]       irq_source,
  output logic [1:0]       ext_request_flag,
  output logic             wake,
  output logic [3:0]       active_levels
);
  typedef struct packed {
    logic [2:0]  mc_cnt;
    logic [1:0]  pin_smp;
    logic [1:0]  ext_flag;
    logic [3:0]  in_service;
    logic        req;
    logic [15:0] vector;
    logic [3:0]  src;
    logic [1:0]  req_level;
    logic        wake;
  } state_t;

  state_t st;
  state_t next_st;
  // pins idle high; a zero sample at reset would fake a level request
  localparam state_t ST_RESET = '{
    mc_cnt: 3'h0, pin_smp: 2'h3, ext_flag: 2'h0, in_service: 4'h0, req: 1'b0,
    vector: intc_pkg::VECTOR_RESET, src: 4'h0, req_level: 2'h0, wake: 1'b0};
  arb_if  arb ();

  prio_arbiter u_arb (
    .a (arb)
  );

  logic [11:0] raw;
  logic [11:0] en;
  logic [15:0] en_all;
  logic        preempt_ok;

  function automatic logic [1:0] top_level(input logic [3:0] s);
    logic [1:0] r;
    r = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (s[l]) begin
        r = 2'(l);
      end
    end
    return r;
  endfunction

  always_comb begin
    raw = {timer_i_flag, comparator_one_flag, watchdog_overflow_flag, comparator_two_flag,
           keypad_flag, i2c_attention_flag, brownout_flag, serial_flag,
           timer_one_overflow, st.ext_flag[1], timer_zero_overflow, st.ext_flag[0]};
    en_all = {irq_enable_reg_b, irq_enable_reg_a};
    for (int i = 0; i < intc_pkg::NUM_SRC; i++) begin
      en[i] = en_all[{intc_pkg::EN_IN_REG_B[i], intc_pkg::EN_BIT_POS[i][2:0]}];
      arb.req[i] = raw[i] && en[i] && irq_enable_reg_a[intc_pkg::EN_A_GATE_BIT];
    end
    for (int i = 0; i < 8; i++) begin
      if (i < 7) begin
        arb.prio[i] = {prio_high_reg_a[i], prio_low_reg_a[i]};
      end
    end
    arb.prio[intc_pkg::SRC_I2C]  = {prio_high_reg_b[0], prio_low_reg_b[0]};
    arb.prio[intc_pkg::SRC_KEY]  = {prio_high_reg_b[1], prio_low_reg_b[1]};
    arb.prio[intc_pkg::SRC_CMP2] = {prio_high_reg_b[2], prio_low_reg_b[2]};
    arb.prio[intc_pkg::SRC_WDOG] = {prio_high_reg_a[6], prio_low_reg_a[6]};
    arb.prio[intc_pkg::SRC_CMP1] = {prio_high_reg_b[5], prio_low_reg_b[5]};
    arb.prio[intc_pkg::SRC_TMRI] = {prio_high_reg_b[7], prio_low_reg_b[7]};
  end

  always_comb begin
    next_st = st;
    // strictly above the running level; level 3 blocks everything
    preempt_ok = (st.in_service == 4'h0) ||
                 (!st.in_service[3] && arb.level > top_level(st.in_service));
    // machine-cycle sampling of the pins
    if (st.mc_cnt == 3'(intc_pkg::MC_CLOCKS - 1)) begin
      next_st.mc_cnt   = 3'h0;
      next_st.pin_smp  = ext_irq_pin_n;
    end else begin
      next_st.mc_cnt = st.mc_cnt + 3'h1;
    end
    for (int n = 0; n < 2; n++) begin
      if (!trigger_type_select[n]) begin
        next_st.ext_flag[n] = !st.pin_smp[n];
      end else begin
        if (irq_ack && st.req && st.src == 4'(n * 2)) begin
          next_st.ext_flag[n] = 1'b0;
        end
        // set wins over the hardware clear
        if (st.mc_cnt == 3'(intc_pkg::MC_CLOCKS - 1) && st.pin_smp[n] && !ext_irq_pin_n[n]) begin
          next_st.ext_flag[n] = 1'b1;
        end
      end
    end
    // nesting stack as a bit per level
    if (irq_return && st.in_service != 4'h0) begin
      next_st.in_service[top_level(st.in_service)] = 1'b0;
    end
    if (irq_ack && st.req) begin
      next_st.in_service[st.req_level] = 1'b1;
    end
    next_st.req       = arb.any && preempt_ok && !(irq_ack && st.req) && !irq_return;
    next_st.src       = arb.idx;
    next_st.req_level = arb.level;
    next_st.vector    = intc_pkg::VECTORS[arb.idx];
    // power-down wakes only from capable sources; idle wakes from any
    next_st.wake = |(arb.req & (power_down ? intc_pkg::WAKE_CAPABLE : 12'hFFF));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    irq_req          = st.req;
    irq_vector       = st.vector;
    irq_source       = st.src;
    ext_request_flag = st.ext_flag;
    wake             = st.wake;
    active_levels    = st.in_service;
  end
endmodule
`default_nettype wire

/* tb/intc_checker.sv */
`default_nettype none
module intc_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  irq_enable_reg_a,
  input wire logic [1:0]  trigger_type_select,
  input wire logic [1:0]  ext_irq_pin_n,
  input wire logic        irq_ack,
  input wire logic        irq_return,
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0]  irq_source,
  input wire logic [1:0]  ext_request_flag,
  input wire logic [3:0]  active_levels
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_vector_table: assert property (irq_req |-> irq_source < 12 &&
    irq_vector == intc_pkg::VECTORS[irq_source]) else $error("vector off table");
  a_gate_blocks: assert property (!irq_enable_reg_a[7] && $past(!irq_enable_reg_a[7])
    |-> !irq_req) else $error("request past closed gate");
  a_top_level_kept: assert property (active_levels[3] && $past(active_levels[3])
    |-> !$rose(irq_req)) else $error("top level preempted");
  a_ack_drops_req: assert property (irq_ack |=> !irq_req) else $error("req after ack");
  a_ack_pushes: assert property (irq_ack |=> active_levels != 0) else $error("no level");
  a_return_drops: assert property (irq_return |=> !irq_req) else $error("req on return");
  a_level_low_sets: assert property ((!trigger_type_select[0] && !ext_irq_pin_n[0]) [*8]
    |-> ext_request_flag[0]) else $error("low level not flagged");
  a_level_high_clr: assert property ((!trigger_type_select[0] && ext_irq_pin_n[0]) [*8]
    |-> !ext_request_flag[0]) else $error("flag not following pin");
endmodule
bind priority_interrupt_controller intc_checker intc_checker_inst (.*);
`default_nettype wire

/* tb/core_model.sv */
`default_nettype none
module core_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic slow,
  input  wire logic irq_req,
  output logic      irq_ack,
  output logic      irq_return
);
  timeunit 1ns;
  timeprecision 1ps;
  // return only once a released pin's flag has settled, else a level source re-raises
  localparam int RET = 10;
  int t, depth;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      t <= 0;
      depth <= 0;
    end else begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      t <= t + 1;
      if (irq_req && !irq_ack && !irq_return && t >= (slow ? 5 : 0)) begin
        irq_ack <= 1'b1;
        depth <= depth + 1;
        t <= 0;
      end else if (depth > 0 && t == RET) begin
        irq_return <= 1'b1;
        depth <= depth - 1;
        t <= 0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/test_priority_interrupt_controller.sv */
`default_nettype none
module test_priority_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, power_down = 1, slow = 0, irq_ack, irq_return;
  logic [7:0] ea = 8'h00, eb = 8'h00, pl = 8'h00, ph = 8'h00, pla = 8'h00, pha = 8'h00;
  logic [1:0] tt = 2'h0, ext_request_flag;
  logic [11:0] s = 12'h000;
  logic irq_req, wake;
  logic [15:0] irq_vector;
  logic [3:0] irq_source, active_levels;
  int failures = 0, checks_done = 0, i;
  // enable a, enable b, vector, wake per source
  logic [35:0] rows [12] = '{36'h810000031, 36'h8200000B0, 36'h840000131, 36'h8800001B0,
    36'h900000230, 36'hA000002B1, 36'h800100330, 36'h8002003B1, 36'h800400431,
    36'hC00000531, 36'h802000631, 36'h808000730};
  logic [15:0] rank [12] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033, 16'h0013,
    16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};
  priority_interrupt_controller priority_interrupt_controller_inst (.*,
    .irq_enable_reg_a(ea), .irq_enable_reg_b(eb), .prio_low_reg_a(pla),
    .prio_high_reg_a(pha), .prio_low_reg_b(pl), .prio_high_reg_b(ph),
    .trigger_type_select(tt), .ext_irq_pin_n(~{s[2], s[0]}), .timer_zero_overflow(s[1]),
    .timer_one_overflow(s[3]), .serial_flag(s[4]), .brownout_flag(s[5]),
    .i2c_attention_flag(s[6]), .keypad_flag(s[7]), .comparator_two_flag(s[8]),
    .watchdog_overflow_flag(s[9]), .comparator_one_flag(s[10]), .timer_i_flag(s[11]));
  core_model core_model_inst (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wack();
    @(posedge clk);
    for (int k = 0; k < 60 && irq_ack !== 1'b1; k++) @(posedge clk);
    chk(irq_ack, 1);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #60us;
    failures++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1;
    repeat (2) @(posedge clk);
    chk({irq_req, wake, ext_request_flag, active_levels}, 0);
    for (i = 0; i < 12; i++) begin
      {ea, eb} <= rows[i][35:20];
      s <= 12'h001 << i;
      wack();
      chk(irq_vector, rows[i][19:4]);
      chk(wake, rows[i][3:0]);
      s <= 12'h000;
      repeat (20) @(posedge clk);
    end
    // gate shut while pin flags settle, so all twelve arrive together
    {ea, eb, slow} <= 17'h0FFFF;
    s <= 12'hFFF;
    repeat (10) @(posedge clk);
    ea[7] <= 1'b1;
    for (i = 0; i < 12; i++) begin
      wack();
      chk(irq_vector, rank[i]);
      s[irq_source] <= 1'b0;
    end
    @(posedge clk);
    {pl, ph, slow} <= 17'h10100;
    s <= 12'hFFF;
    wack();
    chk(irq_vector, 16'h0073);
    s[11] <= 1'b0;
    wack();
    chk(irq_vector, 16'h0003);
    {s, tt, pl, ph} <= 30'h0000_2_0000;
    repeat (40) @(posedge clk);
    s[2] <= 1'b1;
    wack();
    chk(irq_vector, 16'h0013);
    repeat (3) @(posedge clk);
    chk(ext_request_flag[1], 0);
    ea <= 8'h7F;
    s <= 12'hFFA;
    repeat (30) @(posedge clk);
    chk(irq_req, 0);
    {pla, pha} <= 16'h2002;
    s <= 12'h023;
    repeat (10) @(posedge clk);
    ea[7] <= 1'b1;
    wack();
    chk(irq_vector, 16'h000B);
    s <= 12'h021;
    wack();
    chk(irq_vector, 16'h002B);
    s <= 12'h002;
    repeat (10) @(posedge clk);
    chk(wake, 0);
    power_down <= 1'b0;
    repeat (2) @(posedge clk);
    chk(wake, 1);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({ext_request_flag, active_levels}, 0);
    results();
  end
endmodule
`default_nettype wire
